// File: ccmd_pkg.sv
/*
 * Constants for the counter module command interpreter: register map,
 * command codes, status bit positions and timing counts.
 * Assumes a 10 MHz core clock and a 16-bit host register port.
 */
// Functional notes
// - parameterize 71xx: image loaded first; counter bits 1-7, global bit 0
// - store 72xx: image loaded first, then saved for the selected parts
// - rewrite 73xx: saved image copied back, host then reads it
// - restore defaults 74xx: default image loaded, host then reads it
// - host requests memory, proceeds only while firmware is not accessing
// - module toggles watchdog bit; host aborts after 127 silent passes (host model ignores wdog, gives up after 10000 cycles of firmware access)
// - after parameterizing, counters 1-5 stopped, 6-7 running, outputs off (code changes only counters selected in bits 1-7; others keep their state)
package ccmd_pkg;
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned EXEC_US = 2000; // firmware run time of long commands
  localparam int unsigned EXEC_CYC_DEF = (EXEC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WDOG_US = 50; // watchdog half period
  localparam int unsigned WDOG_CYC = (WDOG_US * 1000) / CLK_NS;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ERR = 8'h01;
  localparam logic [7:0] ADDR_ACCESS = 8'h02;
  localparam logic [7:0] ADDR_RUN = 8'h03;
  localparam logic [7:0] ADDR_IMG = 8'h10;
  localparam int unsigned IMG_WORDS = 16;
  localparam logic [7:0] OP_PARAM = 8'h71;
  localparam logic [7:0] OP_STORE = 8'h72;
  localparam logic [7:0] OP_REWRITE = 8'h73;
  localparam logic [7:0] OP_DEFAULT = 8'h74;
  localparam logic [7:0] OP_TEST = 8'h81;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_UNKNOWN = 8'h01;
  localparam logic [7:0] ERR_NOSTORE = 8'h02;
  localparam logic [7:0] ERR_BUSY = 8'h03;
  localparam logic [7:0] ERR_NOREQ = 8'h04;
  localparam logic [7:1] RUN_AUTO = 7'h60; // counters 6 and 7 start by themselves
  localparam logic [15:0] IMG_DEFAULT = 16'h0000;
  localparam logic [15:0] RUN_RESET = 16'h0000;
  localparam int unsigned ST_REQ = 0;
  localparam int unsigned ST_FW = 1;
  localparam int unsigned ST_WDOG = 2;
  localparam int unsigned ST_BUSY = 3;
  localparam int unsigned ST_STORED = 4;
  localparam int unsigned ST_OEN = 8;
  typedef enum logic [2:0] {
    CCMD_IDLE = 3'b001,
    CCMD_EXEC = 3'b010,
    CCMD_DONE = 3'b100
  } ccmd_state_e;
endpackage : ccmd_pkg

// File: ccmd_core.sv
/*
 * Command interpreter of the counter module: parameter image memory,
 * control word execution, memory access interlock and watchdog toggle.
 * Assumes a host on the same clock driving a one-cycle strobe port.
 */
`timescale 1ns/1ps
module ccmd_core import ccmd_pkg::*; #(
  parameter int unsigned EXEC_CYCLES = EXEC_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic [7:1] counter_run,
  output logic outputs_en,
  output logic fw_access,
  output logic wdog
);
  logic rst_meta_reg;
  logic rst_n_reg;
  ccmd_state_e state_reg, state_next;
  logic [15:0] ctl_reg, ctl_next;
  logic [23:0] cnt_reg, cnt_next;
  logic [7:0] err_reg, err_next;
  logic stored_reg, stored_next;
  logic req_reg, req_next;
  logic fw_reg, fw_next;
  logic [7:1] run_reg, run_next;
  logic oen_reg, oen_next;
  logic [15:0] wd_cnt_reg, wd_cnt_next;
  logic wd_reg, wd_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] work_mem [IMG_WORDS];
  logic [15:0] store_mem [IMG_WORDS];
  logic img_hit;
  logic img_grant;
  logic [3:0] img_idx;
  logic [7:0] op;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  assign img_hit = (addr[7:4] == ADDR_IMG[7:4]);
  assign img_idx = addr[3:0];
  assign img_grant = req_reg && !fw_reg; // host owns the image only when firmware is off it
  assign op = ctl_reg[15:8];

  // command sequencing, error capture and register reads
  always_comb begin
    state_next = state_reg;
    ctl_next = ctl_reg;
    cnt_next = cnt_reg;
    err_next = err_reg;
    stored_next = stored_reg;
    req_next = req_reg;
    fw_next = fw_reg;
    run_next = run_reg;
    oen_next = oen_reg;
    rdata_next = RUN_RESET;
    if (rd) begin
      case (addr)
        ADDR_ERR: begin
          rdata_next = {8'h00, err_reg};
          err_next = ERR_NONE; // cleared by reading; a new error below still wins
        end
        ADDR_ACCESS: begin
          rdata_next = RUN_RESET;
          rdata_next[ST_REQ] = req_reg;
          rdata_next[ST_FW] = fw_reg;
          rdata_next[ST_WDOG] = wd_reg;
          rdata_next[ST_BUSY] = (state_reg != CCMD_IDLE);
          rdata_next[ST_STORED] = stored_reg;
        end
        ADDR_RUN: begin
          rdata_next = {7'h00, oen_reg, run_reg, 1'b0};
        end
        default: begin
          if (img_hit && img_grant) begin
            rdata_next = work_mem[img_idx];
          end
        end
      endcase
    end
    if (wr && addr == ADDR_ACCESS) begin
      req_next = wdata[ST_REQ];
    end
    if (wr && img_hit && !img_grant) begin
      err_next = ERR_NOREQ;
    end
    case (state_reg)
      CCMD_IDLE: begin
        if (wr && addr == ADDR_CTRL) begin
          case (wdata[15:8])
            OP_PARAM, OP_STORE, OP_DEFAULT, OP_TEST: begin
              ctl_next = wdata;
              state_next = CCMD_EXEC;
              fw_next = 1'b1;
              cnt_next = 24'(EXEC_CYCLES);
            end
            OP_REWRITE: begin
              if (stored_reg) begin
                ctl_next = wdata;
                state_next = CCMD_EXEC;
                fw_next = 1'b1;
                cnt_next = 24'(EXEC_CYCLES);
              end else begin
                err_next = ERR_NOSTORE; // nothing saved yet
              end
            end
            default: err_next = ERR_UNKNOWN;
          endcase
        end
      end
      CCMD_EXEC: begin
        if (wr && addr == ADDR_CTRL) begin
          err_next = ERR_BUSY; // word lost: host was told busy and must retry
        end
        if (cnt_reg <= 24'h000001) begin
          state_next = CCMD_DONE;
        end else begin
          cnt_next = cnt_reg - 24'h000001;
        end
      end
      CCMD_DONE: begin
        state_next = CCMD_IDLE;
        fw_next = 1'b0;
        if (op == OP_PARAM) begin
          run_next = (run_reg & ~ctl_reg[7:1]) | (RUN_AUTO & ctl_reg[7:1]);
          oen_next = 1'b0;
        end
        if (op == OP_STORE) begin
          stored_next = 1'b1;
        end
      end
      default: begin
        state_next = CCMD_IDLE;
        fw_next = 1'b0;
      end
    endcase
  end

  // watchdog toggles on its own, so it keeps toggling even if the sequencer stalls
  always_comb begin
    wd_cnt_next = wd_cnt_reg + 16'h0001;
    wd_next = wd_reg;
    if (wd_cnt_reg >= 16'(WDOG_CYC - 1)) begin
      wd_cnt_next = 16'h0000;
      wd_next = !wd_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= CCMD_IDLE;
      ctl_reg <= RUN_RESET;
      cnt_reg <= 24'h000000;
      err_reg <= ERR_NONE;
      stored_reg <= 1'b0;
      req_reg <= 1'b0;
      fw_reg <= 1'b0;
      run_reg <= 7'h00;
      oen_reg <= 1'b0;
      wd_cnt_reg <= 16'h0000;
      wd_reg <= 1'b0;
      rdata_reg <= RUN_RESET;
    end else begin
      state_reg <= state_next;
      ctl_reg <= ctl_next;
      cnt_reg <= cnt_next;
      err_reg <= err_next;
      stored_reg <= stored_next;
      req_reg <= req_next;
      fw_reg <= fw_next;
      run_reg <= run_next;
      oen_reg <= oen_next;
      wd_cnt_reg <= wd_cnt_next;
      wd_reg <= wd_next;
      rdata_reg <= rdata_next;
    end
  end

  // image memories; word i belongs to counter i/2, counter 0 is the global set
  always_ff @(posedge clk) begin
    if (wr && img_hit && img_grant) begin
      work_mem[img_idx] <= wdata;
    end
    if (state_reg == CCMD_DONE) begin
      for (int i = 0; i < IMG_WORDS; i++) begin
        if (ctl_reg[i / 2]) begin
          case (op)
            OP_STORE: store_mem[i] <= work_mem[i];
            OP_REWRITE: work_mem[i] <= store_mem[i];
            OP_DEFAULT: work_mem[i] <= IMG_DEFAULT;
            default: ;
          endcase
        end
      end
    end
  end

  assign rdata = rdata_reg;
  assign counter_run = run_reg;
  assign outputs_en = oen_reg;
  assign fw_access = fw_reg;
  assign wdog = wd_reg;

  sequence s_done_op(logic [7:0] code);
    state_reg == CCMD_DONE && op == code;
  endsequence

  a_param_stop: assert property (@(posedge clk) disable iff (!rst_n_reg)
    s_done_op(OP_PARAM) |=> (counter_run & $past(ctl_reg[7:1]) & 7'h1F) == 7'h00 && !outputs_en)
    else $error("parameterized counters 1-5 not stopped or outputs on");
  a_param_auto: assert property (@(posedge clk) disable iff (!rst_n_reg)
    s_done_op(OP_PARAM) ##0 ctl_reg[6] |=> counter_run[6])
    else $error("counter 6 not started after parameterize");
  a_store_copy: assert property (@(posedge clk) disable iff (!rst_n_reg)
    s_done_op(OP_STORE) ##0 ctl_reg[1] |=> store_mem[2] == $past(work_mem[2]) && stored_reg)
    else $error("store did not save selected counter image");
  a_rewrite_copy: assert property (@(posedge clk) disable iff (!rst_n_reg)
    s_done_op(OP_REWRITE) ##0 ctl_reg[0] |=> work_mem[0] == $past(store_mem[0]))
    else $error("rewrite did not restore global image");
  a_default_load: assert property (@(posedge clk) disable iff (!rst_n_reg)
    s_done_op(OP_DEFAULT) ##0 ctl_reg[3] |=> work_mem[6] == IMG_DEFAULT)
    else $error("default not loaded into selected counter");
  a_access_lock: assert property (@(posedge clk) disable iff (!rst_n_reg)
    wr && img_hit && fw_access && state_reg == CCMD_EXEC |=>
    work_mem[$past(img_idx)] == $past(work_mem[img_idx]))
    else $error("host wrote image while firmware held it");
  a_exec_hold: assert property (@(posedge clk) disable iff (!rst_n_reg)
    $rose(fw_access) |-> fw_access [*8] ##1 (state_reg != CCMD_IDLE))
    else $error("firmware access dropped early");
  a_wdog_toggle: assert property (@(posedge clk) disable iff (!rst_n_reg)
    wd_cnt_reg == 16'(WDOG_CYC - 1) |=> wdog != $past(wdog) ##1 $stable(wdog))
    else $error("watchdog did not toggle on schedule");
endmodule : ccmd_core

// File: ccmd_host.sv
/* host-side model for the command interpreter: register bus cycles, memory request,
   bounded wait on firmware. assumes one clock shared with ccmd_core. */
`timescale 1ns/1ps
module ccmd_host import ccmd_pkg::*; (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata,
  input wire logic fw_access
);
  // one millisecond of host cycles bounds every wait on the firmware
  localparam int unsigned WAIT_CYC = 1000000 / CLK_NS;
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // fields change after an edge and are held until the taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // data stand only in the cycle after the strobe, so look inside that cycle
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  // raise or drop the memory request bit
  task automatic request(input logic on);
    wr_reg(ADDR_ACCESS, {15'h0000, on});
  endtask : request
  // error read before a control word; a nonzero code means the word is held back
  task automatic pre_check(output logic [15:0] err, output logic [7:0] status);
    rd_reg(ADDR_ERR, err);
    status = 8'h00;
    if (err !== 16'h0000) begin
      status[3] = 1'b1;
      status[4] = 1'b1;
    end
    status[7] = |status[6:0];
  endtask : pre_check
  // own cycle counter bounds the wait for firmware to let go
  task automatic wait_idle(output logic late);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (fw_access !== 1'b0 && n < WAIT_CYC) begin
      @(posedge clk);
      #1;
      n++;
    end
    late = (n >= WAIT_CYC);
  endtask : wait_idle
endmodule : ccmd_host

// File: tb.sv
/* self-checking bench for ccmd_core: commands, refusals, image access, watchdog.
   assumes ccmd_host drives the register port; exec time shortened to 20 cycles. */
`timescale 1ns/1ps
module tb import ccmd_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [7:1] counter_run;
  logic outputs_en;
  logic fw_access;
  logic wdog;
  logic [15:0] rv;
  logic late;
  logic [7:0] st;
  int n_errors = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  ccmd_core #(.EXEC_CYCLES(20)) ccmd_core_inst (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .counter_run(counter_run),
    .outputs_en(outputs_en), .fw_access(fw_access), .wdog(wdog));
  ccmd_host ccmd_host_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fw_access(fw_access));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  // issue a control word, let it finish, then read and clear the error code
  task automatic cmd(input logic [15:0] w, input logic [7:0] e);
    ccmd_host_inst.wr_reg(ADDR_CTRL, w);
    ccmd_host_inst.wait_idle(late);
    chk("late", {15'h0000, late}, 16'h0000);
    ccmd_host_inst.rd_reg(ADDR_ERR, rv);
    chk("error", rv, {8'h00, e});
  endtask : cmd
  // words refused before any image work
  task automatic t_refuse();
    chk("run", {7'h00, outputs_en, counter_run, 1'b0}, 16'h0000);
    cmd({OP_REWRITE, 8'hFF}, ERR_NOSTORE);
    cmd(16'h5500, ERR_UNKNOWN);
    cmd(16'hFF00, ERR_UNKNOWN);
    ccmd_host_inst.wr_reg(ADDR_IMG, 16'hA5A5);
    ccmd_host_inst.pre_check(rv, st);
    chk("noreq", rv, {8'h00, ERR_NOREQ});
    chk("status", {8'h00, st}, 16'h0098);
    ccmd_host_inst.rd_reg(ADDR_IMG, rv);
    chk("img_noreq", rv, 16'h0000);
  endtask : t_refuse
  // load image, parameterize, second word while executing is refused
  task automatic t_param();
    ccmd_host_inst.request(1'b1);
    for (int i = 0; i < IMG_WORDS; i++) begin
      ccmd_host_inst.wr_reg(ADDR_IMG + 8'(i), 16'h1000 + 16'(i));
    end
    ccmd_host_inst.wr_reg(ADDR_CTRL, {OP_PARAM, 8'hFF});
    ccmd_host_inst.wr_reg(ADDR_CTRL, {OP_STORE, 8'hFF});
    ccmd_host_inst.wr_reg(ADDR_IMG + 8'h01, 16'hBEEF);
    ccmd_host_inst.rd_reg(ADDR_IMG, rv);
    chk("img_busy", rv, 16'h0000);
    cmd(16'h0000, ERR_BUSY);
    ccmd_host_inst.rd_reg(ADDR_IMG + 8'h01, rv);
    chk("img_kept", rv, 16'h1001);
    ccmd_host_inst.rd_reg(ADDR_RUN, rv);
    chk("run_reg", rv, {7'h00, 1'b0, RUN_AUTO, 1'b0});
    chk("run_port", {7'h00, outputs_en, counter_run, 1'b0}, {8'h00, RUN_AUTO, 1'b0});
  endtask : t_param
  // store, spoil the work copy, rewrite restores it, defaults clear it, test runs
  task automatic t_store();
    cmd({OP_STORE, 8'hFF}, ERR_NONE);
    ccmd_host_inst.rd_reg(ADDR_ACCESS, rv);
    chk("status", rv & 16'hFFFB, 16'h0011);
    ccmd_host_inst.wr_reg(ADDR_IMG, 16'hFFFF);
    cmd({OP_REWRITE, 8'hFF}, ERR_NONE);
    ccmd_host_inst.rd_reg(ADDR_IMG, rv);
    chk("rewrite", rv, 16'h1000);
    // bulk read of the whole restored image, no control word involved
    for (int i = 0; i < IMG_WORDS; i++) begin
      ccmd_host_inst.rd_reg(ADDR_IMG + 8'(i), rv);
      chk("bulk", rv, 16'h1000 + 16'(i));
    end
    cmd({OP_DEFAULT, 8'hFF}, ERR_NONE);
    ccmd_host_inst.rd_reg(ADDR_IMG + 8'h05, rv);
    chk("default", rv, IMG_DEFAULT);
    ccmd_host_inst.wr_reg(ADDR_CTRL, {OP_TEST, 8'h01});
    @(posedge clk);
    #1;
    chk("test_busy", {15'h0000, fw_access}, 16'h0001);
    ccmd_host_inst.wait_idle(late);
    chk("test_late", {15'h0000, late}, 16'h0000);
    cmd(16'h0000, ERR_UNKNOWN);
    ccmd_host_inst.request(1'b0);
  endtask : t_store
  // watchdog changes twice, each within its half period
  task automatic t_wdog();
    logic w;
    int n;
    for (int k = 0; k < 2; k++) begin
      w = wdog;
      n = 0;
      while (wdog === w && n < 600) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("wdog", {15'h0000, wdog}, {15'h0000, ~w});
      chk("wdog_time", {15'h0000, n <= WDOG_CYC}, 16'h0001);
    end
  endtask : t_wdog
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_refuse();
    t_param();
    t_store();
    t_wdog();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule : tb
